// file: rtl/scf_deb_if.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// one debounce path: raw comparator, interval, filtered fault
// ---------------------------------------------------------------
interface scf_deb_if;
  import scf_pkg::*;
  logic                     raw;
  logic [SCF_CNT_WIDTH-1:0] duration;
  logic                     filtered;
  modport ctrl (output raw, output duration, input filtered);
  modport filt (input raw, input duration, output filtered);
endinterface
`default_nettype wire

// file: rtl/scf_debounce.sv
`timescale 1ns/100ps
`default_nettype none
module scf_debounce
  import scf_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  scf_deb_if.filt    deb
);

  logic [SCF_CNT_WIDTH-1:0] stable_cnt;
  logic [SCF_CNT_WIDTH-1:0] next_stable_cnt;
  logic                     next_filtered;

  // ---------------------------------------------------------------
  // stability counter, saturates at the selected interval
  // ---------------------------------------------------------------
  assign next_stable_cnt = !deb.raw ? '0 :
                           (stable_cnt >= deb.duration) ? stable_cnt : stable_cnt + 1'b1;
  assign next_filtered   = deb.raw && (next_stable_cnt >= deb.duration); // see RQ5

  // counter and filtered flag registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stable_cnt   <= '0;
      deb.filtered <= 1'b0;
    end else begin
      stable_cnt   <= next_stable_cnt;
      deb.filtered <= next_filtered;
    end
  end

endmodule
`default_nettype wire

// file: rtl/scf_pkg.sv
package scf_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SCF_OFS_CH6_OV_THR  = 8'h71;
  localparam logic [7:0] SCF_OFS_CH6_DEB_SEL = 8'h74;
  localparam logic [7:0] SCF_OFS_CH6_ROUTE   = 8'h75;
  localparam logic [7:0] SCF_OFS_CH7_UV_THR  = 8'h80;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int SCF_OV_FILTER_MSB   = 7;
  localparam int SCF_OV_FILTER_LSB   = 4;
  localparam int SCF_UV_FILTER_MSB   = 3;
  localparam int SCF_UV_FILTER_LSB   = 0;
  localparam int SCF_OV_ROUTE_BIT    = 4;
  localparam int SCF_UV_ROUTE_BIT    = 3;
  localparam logic [7:0] SCF_ROUTE_WMASK  = 8'h18;
  localparam logic [7:0] SCF_RST_THR      = 8'h00;
  localparam logic [7:0] SCF_RST_DEB_SEL  = 8'h00;
  localparam logic [7:0] SCF_RST_ROUTE    = 8'h00;

  // ---------------------------------------------------------------
  // threshold scaling, millivolts
  // ---------------------------------------------------------------
  localparam int SCF_MV_WIDTH        = 13;
  localparam logic [12:0] SCF_MV_BASE_1X = 13'h00c8; // 200 mV
  localparam logic [12:0] SCF_MV_STEP_1X = 13'h0005; // 5 mV
  localparam logic [12:0] SCF_MV_BASE_4X = 13'h0320; // 800 mV
  localparam logic [12:0] SCF_MV_STEP_4X = 13'h0014; // 20 mV

  // ---------------------------------------------------------------
  // debounce timing
  // ---------------------------------------------------------------
  localparam int SCF_CLK_MHZ         = 100;
  localparam int SCF_DEB_BASE_NS     = 100;    // 0.1 us shortest code
  localparam int SCF_DEB_LONGEST_NS  = 102400; // 102.4 us
  localparam int SCF_DEB_BASE_CYC    = (SCF_DEB_BASE_NS * SCF_CLK_MHZ + 999) / 1000;
  localparam int SCF_DEB_LONGEST_CYC = (SCF_DEB_LONGEST_NS * SCF_CLK_MHZ + 999) / 1000;
  localparam int SCF_DEB_CODE_LAST   = 9;      // last doubling code
  localparam int SCF_CNT_WIDTH       = 14;

endpackage

// file: rtl/scf_top.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RQ1: channel 6 fast overvoltage threshold, 8-bit read/write at 0x71.
// RQ2: threshold codes are read through the external range scaling setting.
// RQ3: 1x scaling: 200 mV plus 5 mV per code step.
// RQ4: 4x scaling: 800 mV plus 20 mV per code step.
// RQ5: a fault rises only after the raw comparator stays high the whole interval.
// RQ6: bits 7-4 at 0x74 pick overvoltage interval, 0.1 us doubling, above 9 is 102.4 us.
// RQ7: bits 3-0 at 0x74 pick undervoltage interval from the same table.
// RQ8: bit 4 at 0x75 routes channel 6 overvoltage fault to the reset pin.
// RQ9: bit 3 at 0x75 routes channel 6 undervoltage fault to the reset pin.
// RQ10: channel 7 fast undervoltage threshold, 8-bit read/write at 0x80, same scaling.
// RQ11: unused bits of 0x75 read zero and ignore writes.
// RQ12: reset pin is pulled low while any routed filtered fault is present.
module scf_top
  import scf_pkg::*;
#(
  parameter int DEB_BASE_CYCLES    = SCF_DEB_BASE_CYC,
  parameter int DEB_LONGEST_CYCLES = SCF_DEB_LONGEST_CYC
) (
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // scaling and raw comparator inputs
  input  wire logic                    range_scale_4x,
  input  wire logic                    ch6_ov_raw,
  input  wire logic                    ch6_uv_raw,
  // scaled thresholds, filtered faults and reset pin
  output logic      [SCF_MV_WIDTH-1:0] ch6_ov_threshold_mv,
  output logic      [SCF_MV_WIDTH-1:0] ch7_uv_threshold_mv,
  output logic                         ch6_ov_fault,
  output logic                         ch6_uv_fault,
  output logic                         reset_out_o,
  output logic                         reset_out_oe_n
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // code to millivolts under the selected scaling
  function automatic logic [SCF_MV_WIDTH-1:0] code_to_mv(input logic [7:0] code, input logic scale4);
    logic [SCF_MV_WIDTH-1:0] wide;
    // widened first so the product cannot wrap
    wide = {{(SCF_MV_WIDTH-8){1'b0}}, code};
    if (scale4) begin
      code_to_mv = SCF_MV_BASE_4X + SCF_MV_WIDTH'(wide * SCF_MV_STEP_4X); // see RQ4
    end else begin
      code_to_mv = SCF_MV_BASE_1X + SCF_MV_WIDTH'(wide * SCF_MV_STEP_1X); // see RQ3
    end
  endfunction

  // debounce code to interval in clock cycles
  function automatic logic [SCF_CNT_WIDTH-1:0] code_to_cycles(input logic [3:0] code);
    logic [SCF_CNT_WIDTH-1:0] base;
    base = SCF_CNT_WIDTH'(DEB_BASE_CYCLES);
    // every code past the last doubling step selects the longest interval
    if (int'(code) > SCF_DEB_CODE_LAST) begin
      code_to_cycles = SCF_CNT_WIDTH'(DEB_LONGEST_CYCLES);
    end else begin
      code_to_cycles = base << code;
    end
  endfunction

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] ch6_fast_overvoltage_threshold;
  logic [7:0] ch6_fast_debounce_select;
  logic [7:0] ch6_fault_reset_routing;
  logic [7:0] ch7_fast_undervoltage_threshold;

  // address decode
  // full byte compare, so an unmapped offset hits nothing
  wire hit_ov_thr  = (reg_addr == SCF_OFS_CH6_OV_THR);
  wire hit_deb_sel = (reg_addr == SCF_OFS_CH6_DEB_SEL);
  wire hit_route   = (reg_addr == SCF_OFS_CH6_ROUTE);
  wire hit_uv_thr  = (reg_addr == SCF_OFS_CH7_UV_THR);

  // write enables, one per register
  wire wen_ov_thr  = reg_wr && hit_ov_thr;
  wire wen_deb_sel = reg_wr && hit_deb_sel;
  wire wen_route   = reg_wr && hit_route;
  wire wen_uv_thr  = reg_wr && hit_uv_thr;

  // reserved routing bits are dropped before they are stored
  wire [7:0] route_wdata = reg_wdata & SCF_ROUTE_WMASK; // see RQ11

  // all four registers reset to zero, their power-up contents being otherwise undefined
  // channel 6 overvoltage threshold
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ch6_fast_overvoltage_threshold <= SCF_RST_THR;
    end else if (wen_ov_thr) begin
      ch6_fast_overvoltage_threshold <= reg_wdata; // see RQ1
    end
  end

  // channel 6 debounce codes, overvoltage high nibble, undervoltage low nibble
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ch6_fast_debounce_select <= SCF_RST_DEB_SEL;
    end else if (wen_deb_sel) begin
      ch6_fast_debounce_select <= reg_wdata; // see RQ6 see RQ7
    end
  end

  // channel 6 fault routing, only the two route bits are stored
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ch6_fault_reset_routing <= SCF_RST_ROUTE;
    end else if (wen_route) begin
      ch6_fault_reset_routing <= route_wdata; // see RQ11
    end
  end

  // channel 7 undervoltage threshold
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ch7_fast_undervoltage_threshold <= SCF_RST_THR;
    end else if (wen_uv_thr) begin
      ch7_fast_undervoltage_threshold <= reg_wdata; // see RQ10
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read select: unmapped offsets give zero
  // a write in the same cycle is not seen yet, the old contents are returned
  wire [7:0] rd_mux = hit_ov_thr  ? ch6_fast_overvoltage_threshold :
                      hit_deb_sel ? ch6_fast_debounce_select :
                      hit_route   ? ch6_fault_reset_routing :
                      hit_uv_thr  ? ch7_fast_undervoltage_threshold : 8'h00;

  // read data register, updated on each read strobe
  // the host sees the value one edge after its strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // threshold scaling
  // ---------------------------------------------------------------
  // code to millivolts, recomputed every cycle
  // a scaling change shows on the outputs one edge later
  wire [SCF_MV_WIDTH-1:0] next_ov_mv = code_to_mv(ch6_fast_overvoltage_threshold, range_scale_4x);
  wire [SCF_MV_WIDTH-1:0] next_uv_mv = code_to_mv(ch7_fast_undervoltage_threshold, range_scale_4x);

  // channel 6 overvoltage threshold in millivolts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ch6_ov_threshold_mv <= SCF_MV_BASE_1X;
    end else begin
      ch6_ov_threshold_mv <= next_ov_mv; // see RQ2
    end
  end

  // channel 7 undervoltage threshold in millivolts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ch7_uv_threshold_mv <= SCF_MV_BASE_1X;
    end else begin
      ch7_uv_threshold_mv <= next_uv_mv; // see RQ2
    end
  end

  // ---------------------------------------------------------------
  // debounce paths: index 0 overvoltage, index 1 undervoltage
  // ---------------------------------------------------------------
  // field slices gathered into per-path vectors
  wire [3:0] ov_code  = ch6_fast_debounce_select[SCF_OV_FILTER_MSB:SCF_OV_FILTER_LSB];
  wire [3:0] uv_code  = ch6_fast_debounce_select[SCF_UV_FILTER_MSB:SCF_UV_FILTER_LSB];
  wire [1:0] raw_vec  = {ch6_uv_raw, ch6_ov_raw};
  wire [7:0] code_vec = {uv_code, ov_code};
  wire [1:0] flt_vec;

  // one interface per path, control side here, filter side in the submodule
  scf_deb_if deb_bus [2] ();

  // only assertion is debounced; a fault clears on the first low raw sample
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_path
      assign deb_bus[gi].raw      = raw_vec[gi];
      assign deb_bus[gi].duration = code_to_cycles(code_vec[gi*4 +: 4]); // see RQ6 see RQ7
      assign flt_vec[gi]          = deb_bus[gi].filtered;
      scf_debounce u_deb (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .deb     (deb_bus[gi].filt)
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // fault routing to the open-drain reset pin
  // ---------------------------------------------------------------
  // a fault reaches the pin only with its route bit set
  wire ov_routed = flt_vec[0] && ch6_fault_reset_routing[SCF_OV_ROUTE_BIT]; // see RQ8
  wire uv_routed = flt_vec[1] && ch6_fault_reset_routing[SCF_UV_ROUTE_BIT]; // see RQ9

  // filtered fault flags come straight from the debounce flops
  assign ch6_ov_fault   = flt_vec[0];
  assign ch6_uv_fault   = flt_vec[1];

  // open drain: data tied low, only the enable moves, and a low enable pulls the pin
  assign reset_out_o    = 1'b0;                      // open drain only pulls low
  assign reset_out_oe_n = !(ov_routed || uv_routed); // see RQ12

endmodule
`default_nettype wire

// file: test/scf_checker.sv
`timescale 1ns/100ps
`default_nettype none
module scf_checker
  import scf_pkg::*;
#(
  parameter int DEB_BASE_CYCLES    = SCF_DEB_BASE_CYC,
  parameter int DEB_LONGEST_CYCLES = SCF_DEB_LONGEST_CYC
) (
  input wire logic                    clk_sys,
  input wire logic                    arst_n,
  input wire logic [7:0]              reg_addr,
  input wire logic                    reg_wr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    range_scale_4x,
  input wire logic                    ch6_ov_raw,
  input wire logic                    ch6_uv_raw,
  input wire logic [SCF_MV_WIDTH-1:0] ch6_ov_threshold_mv,
  input wire logic [SCF_MV_WIDTH-1:0] ch7_uv_threshold_mv,
  input wire logic                    ch6_ov_fault,
  input wire logic                    ch6_uv_fault,
  input wire logic                    reset_out_o,
  input wire logic                    reset_out_oe_n
);
  logic [7:0]  ov_thr, deb_sel, route, uv_thr;
  logic [13:0] ov_run, uv_run;
  function automatic logic [12:0] to_mv(input logic [7:0] c, input logic s);
    return s ? SCF_MV_BASE_4X + SCF_MV_STEP_4X * c : SCF_MV_BASE_1X + SCF_MV_STEP_1X * c;
  endfunction
  // debounce code to interval in cycles
  function automatic logic [13:0] to_cyc(input logic [3:0] c);
    return (int'(c) > SCF_DEB_CODE_LAST) ? 14'(DEB_LONGEST_CYCLES) : 14'(DEB_BASE_CYCLES) << c;
  endfunction
  // shadow copies of the registers and raw high-run counts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {ov_thr, deb_sel, route, uv_thr, ov_run, uv_run} <= '0;
    end else begin
      if (reg_wr && reg_addr == SCF_OFS_CH6_OV_THR) ov_thr <= reg_wdata;
      if (reg_wr && reg_addr == SCF_OFS_CH6_DEB_SEL) deb_sel <= reg_wdata;
      if (reg_wr && reg_addr == SCF_OFS_CH6_ROUTE) route <= reg_wdata & SCF_ROUTE_WMASK;
      if (reg_wr && reg_addr == SCF_OFS_CH7_UV_THR) uv_thr <= reg_wdata;
      ov_run <= ch6_ov_raw ? ov_run + 14'h1 : 14'h0;
      uv_run <= ch6_uv_raw ? uv_run + 14'h1 : 14'h0;
    end
  end
  // expected read data and threshold values
  wire logic [7:0]  rd_exp = (reg_addr == SCF_OFS_CH6_OV_THR) ? ov_thr : (reg_addr == SCF_OFS_CH6_DEB_SEL) ? deb_sel :
                             (reg_addr == SCF_OFS_CH6_ROUTE) ? route : (reg_addr == SCF_OFS_CH7_UV_THR) ? uv_thr : 8'h00;
  wire logic [12:0] ov_mv  = to_mv(ov_thr, range_scale_4x);
  wire logic [12:0] uv_mv  = to_mv(uv_thr, range_scale_4x);
  wire logic [13:0] ov_need = to_cyc(deb_sel[SCF_OV_FILTER_MSB:SCF_OV_FILTER_LSB]);
  wire logic [13:0] uv_need = to_cyc(deb_sel[SCF_UV_FILTER_MSB:SCF_UV_FILTER_LSB]);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  read_data_a: assert property (reg_rd |=> reg_rdata == $past(rd_exp)) else $error("read data mismatch");
  read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  ov_scale_a: assert property ($past(arst_n) |-> ch6_ov_threshold_mv == $past(ov_mv))
    else $error("ov threshold mv wrong");
  uv_scale_a: assert property ($past(arst_n) |-> ch7_uv_threshold_mv == $past(uv_mv))
    else $error("uv threshold mv wrong");
  ov_debounce_a: assert property ($rose(ch6_ov_fault) |-> ov_run >= $past(ov_need))
    else $error("ov fault early");
  uv_debounce_a: assert property ($rose(ch6_uv_fault) |-> uv_run >= $past(uv_need))
    else $error("uv fault early");
  fault_drop_a: assert property (!ch6_ov_raw && !ch6_uv_raw |=> !ch6_ov_fault && !ch6_uv_fault) else $error("fault stuck");
  pin_route_a: assert property (reset_out_oe_n == !((ch6_ov_fault && route[4]) || (ch6_uv_fault && route[3])))
    else $error("reset pin wrong");
  pin_low_a: assert property (reset_out_o == 1'b0) else $error("pin data not low");
  cover property ($rose(ch6_ov_fault));
  cover property ($rose(ch6_uv_fault));
  cover property (!reset_out_oe_n);
endmodule
bind scf_top scf_checker #(.DEB_BASE_CYCLES(DEB_BASE_CYCLES), .DEB_LONGEST_CYCLES(DEB_LONGEST_CYCLES)) i_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .range_scale_4x(range_scale_4x), .ch6_ov_raw(ch6_ov_raw),
  .ch6_uv_raw(ch6_uv_raw), .ch6_ov_threshold_mv(ch6_ov_threshold_mv), .ch7_uv_threshold_mv(ch7_uv_threshold_mv),
  .ch6_ov_fault(ch6_ov_fault), .ch6_uv_fault(ch6_uv_fault), .reset_out_o(reset_out_o), .reset_out_oe_n(reset_out_oe_n));
`default_nettype wire

// file: test/scf_host.sv
`timescale 1ns/100ps
`default_nettype none
module scf_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_rd
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  // one write strobe, data shows its inverse once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk_sys);
    {reg_wdata, reg_wr} = {~d, 1'b0};
  endtask
  // one read strobe, data taken after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import scf_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} scf_row_type;
  localparam int DEB_BASE = 2;
  localparam int DEB_LONG = 64;
  logic        clk_sys = 0, arst_n = 0, scale = 0, ov_raw = 0, uv_raw = 0, ov_f, uv_f, pin_o, oe_n, wr, rd_s;
  logic [7:0]  addr, wdata, rdata, q;
  logic [12:0] ov_mv, uv_mv;
  int          err_total = 0, tests_run = 0;
  scf_row_type rows [5] = '{'{8'h71, 8'hff, 8'hff}, '{8'h74, 8'h3c, 8'h3c}, '{8'h75, 8'hff, 8'h18},
                            '{8'h80, 8'h5a, 8'h5a}, '{8'h72, 8'hff, 8'h00}};
  always #5 clk_sys = ~clk_sys;
  scf_host i_host (.clk_sys(clk_sys), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd_s));
  scf_top #(.DEB_BASE_CYCLES(DEB_BASE), .DEB_LONGEST_CYCLES(DEB_LONG)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(addr),
    .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd_s), .reg_rdata(rdata), .range_scale_4x(scale), .ch6_ov_raw(ov_raw),
    .ch6_uv_raw(uv_raw), .ch6_ov_threshold_mv(ov_mv), .ch7_uv_threshold_mv(uv_mv), .ch6_ov_fault(ov_f),
    .ch6_uv_fault(uv_f), .reset_out_o(pin_o), .reset_out_oe_n(oe_n));
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [12:0] mv(input logic [7:0] c, input logic s);
    return s ? SCF_MV_BASE_4X + SCF_MV_STEP_4X * c : SCF_MV_BASE_1X + SCF_MV_STEP_1X * c;
  endfunction
  // short pulse, restart, then a full interval on one path
  task automatic deb(input logic [3:0] code, input logic ov, input logic rt);
    int n;
    n = (code > 4'h9) ? DEB_LONG : DEB_BASE << code;
    i_host.wr(SCF_OFS_CH6_DEB_SEL, ov ? {code, 4'h0} : {4'h0, code});
    i_host.wr(SCF_OFS_CH6_ROUTE, {3'h7, ov & rt, ~ov & rt, 3'h7});
    {ov_raw, uv_raw} = {ov, ~ov};
    repeat (n - 1) @(negedge clk_sys);
    {ov_raw, uv_raw} = 2'b00;
    @(negedge clk_sys);
    {ov_raw, uv_raw} = {ov, ~ov};
    repeat (n - 1) @(negedge clk_sys);
    chk("fault early", 13'h0, {12'h0, ov_f | uv_f});
    @(negedge clk_sys);
    chk("fault", 13'h1, {12'h0, ov ? ov_f : uv_f});
    chk("reset pin", {12'h0, ~rt}, {12'h0, oe_n});
    {ov_raw, uv_raw} = 2'b00;
    @(negedge clk_sys);
    chk("fault drop", 13'h0, {12'h0, ov_f | uv_f});
  endtask
  // watchdog
  initial begin
    #50000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    arst_n = 1;
    @(negedge clk_sys);
    chk("ov mv reset", mv(8'h00, 1'b0), ov_mv);
    chk("pin reset", 13'h1, {12'h0, oe_n});
    chk("pin data", 13'h0, {12'h0, pin_o});
    foreach (rows[i]) begin
      i_host.wr(rows[i].a, rows[i].d);
      i_host.rd(rows[i].a, q);
      chk("readback", {5'h0, rows[i].q}, {5'h0, q});
    end
    for (int s = 0; s < 2; s++) begin
      scale = s[0];
      repeat (2) @(negedge clk_sys);
      chk("ov mv", mv(8'hff, scale), ov_mv);
      chk("uv mv", mv(8'h5a, scale), uv_mv);
    end
    scale = 0;
    deb(4'h0, 1'b1, 1'b1);
    deb(4'h2, 1'b0, 1'b1);
    deb(4'hf, 1'b1, 1'b0);
    deb(4'ha, 1'b0, 1'b0);
    i_host.wr(SCF_OFS_CH6_ROUTE, 8'hff);
    i_host.rd(SCF_OFS_CH7_UV_THR, q);
    chk("uv thr before reset", 13'h05a, {5'h0, q});
    arst_n = 0;
    repeat (2) @(negedge clk_sys);
    chk("rdata reset", 13'h0, {5'h0, rdata});
    arst_n = 1;
    i_host.rd(SCF_OFS_CH6_ROUTE, q);
    chk("route reset", {5'h0, SCF_RST_ROUTE}, {5'h0, q});
    i_host.rd(SCF_OFS_CH7_UV_THR, q);
    chk("uv thr reset", {5'h0, SCF_RST_THR}, {5'h0, q});
    final_report();
  end
endmodule
`default_nettype wire
